// ---- core/twr_pkg.sv ----
// Shared constants and types for the two-wire register access link
package twr_pkg;

  // Master bit timing: one link bit is four quarter steps of the system clock
  localparam int          SYS_CLK_NS    = 20;
  localparam int          SCL_PERIOD_NS = 2500;
  localparam int          QTR_CYC       = (SCL_PERIOD_NS + 4 * SYS_CLK_NS - 1) / (4 * SYS_CLK_NS);
  localparam logic [5:0]  QTR_LAST      = 6'(QTR_CYC - 1);

  // Target identity, seven-bit form of write/read address bytes
  localparam logic [6:0]  DEV_ID_DEF    = 7'h10;
  localparam logic [6:0]  DEV_ID_ALT    = 7'h18;

  // Bit counter landmarks within one byte slot
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [3:0]  BIT_ACK_END   = 4'h9;

  // Reset values
  localparam logic [15:0] PTR_RST       = 16'h0000;
  localparam logic [7:0]  BYTE_RST      = 8'h00;
  localparam logic [7:0]  BYTE_IDLE     = 8'hff;

  // Master transaction kinds
  typedef enum logic [1:0] {
    TWR_OP_WRITE,
    TWR_OP_READ_RAND,
    TWR_OP_READ_CUR
  } twr_op_t;

endpackage

// ---- core/twr_link_if.sv ----
// Two-wire link between master and target, open-drain data resolved here
`timescale 1ns/1ns
interface twr_link_if;
  logic scl;
  logic m_sda_oe;
  logic m_sda_out;
  logic d_sda_oe;
  logic d_sda_out;
  logic sda;

  // Wired-AND with external pull-up: any enabled low driver wins
  assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

  modport master (
    output scl,
    output m_sda_oe,
    output m_sda_out,
    input  sda
  );

  modport device (
    input  scl,
    input  sda,
    output d_sda_oe,
    output d_sda_out
  );
endinterface

// ---- core/twr_sync2.sv ----
// Two-stage synchroniser for levels and toggles
`timescale 1ns/1ns
module twr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_reg <= '0;
      q_out    <= '0;
    end
    else
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// ---- core/twr_target.sv ----
// Two-wire register access target: link side on link clock, register port on system clock
`timescale 1ns/1ns

// Functional notes
// - Master loads pointer by address-only write
// - Master ends address write with restart
// - Read address byte, target returns one byte
// - Master ends read with NACK, stop
// - Target holds pointer loaded from address bytes
// - Plain read returns data at current pointer
// - Master acks; target supplies successive bytes
// - Write: start, address byte, high, low
// - One data byte stored at pointer, stop
// - Further data bytes go to successive addresses
// - Pointer advances after every eight data bits
// - Answer 0x20/0x21, or 0x30/0x31 when selected
// - Clock only sampled, never held low
// - Acknowledge every matched or received byte
module twr_target
  import twr_pkg::*;
(
  // Clocks and reset
  input  wire logic        link_clk_in,
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Link
  twr_link_if.device       link_if,
  // Address select straps
  input  wire logic        addr_sel_en_in,
  input  wire logic        addr_sel_in,
  // Register port
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic [15:0]      reg_addr_out,
  output logic [7:0]       reg_wdata_out,
  input  wire logic [7:0]  reg_rdata_in
);

  typedef enum logic [2:0] {
    D_IDLE,
    D_DEVADDR,
    D_RX,
    D_TX,
    D_WAIT
  } twr_dev_state_t;

  // Link domain state
  twr_dev_state_t state_reg;
  logic [3:0]     bit_cnt_reg;
  logic [7:0]     shift_reg;
  logic           ack_drv_reg;
  logic           rd_mode_reg;
  logic [1:0]     byte_idx_reg;
  logic [7:0]     addr_hi_reg;
  logic [15:0]    ptr_reg;
  logic [7:0]     tx_byte_reg;
  logic [7:0]     rdata_link_reg;
  logic           sda_oe_reg;
  logic           sda_out_reg;
  logic           scl_q_reg;
  logic           sda_q_reg;
  logic           ack_q_reg;
  // Link-to-system request, held stable while the toggle crosses
  logic           req_tgl_reg;
  logic           req_wr_reg;
  logic [15:0]    req_addr_reg;
  logic [7:0]     req_data_reg;
  // System domain state
  logic           req_q_reg;
  logic           rd_pend_reg;
  logic           ack_tgl_reg;
  logic [7:0]     rdata_sys_reg;

  logic [3:0]     pins_s;
  logic           scl_s;
  logic           sda_s;
  logic           sel_en_s;
  logic           sel_s;
  logic           ack_s;
  logic           req_s;

  logic           start_ev;
  logic           stop_ev;
  logic           scl_rise;
  logic           scl_fall;
  logic [6:0]     my_id;
  logic [7:0]     byte_w;
  logic           rx_state;
  logic           byte_done;
  logic           hit;
  logic           rx_store;
  logic           tx_done;
  logic           master_ack;
  logic           rd_issue;
  logic           wr_issue;

  twr_sync2 #(
    .W (4)
  ) u_pin_sync (
    .clk_in (link_clk_in),
    .rst_in (rst_in),
    .d_in   ({link_if.scl, link_if.sda, addr_sel_en_in, addr_sel_in}),
    .q_out  (pins_s)
  );

  twr_sync2 #(
    .W (1)
  ) u_ack_sync (
    .clk_in (link_clk_in),
    .rst_in (rst_in),
    .d_in   (ack_tgl_reg),
    .q_out  (ack_s)
  );

  twr_sync2 #(
    .W (1)
  ) u_req_sync (
    .clk_in (sys_clk_in),
    .rst_in (rst_in),
    .d_in   (req_tgl_reg),
    .q_out  (req_s)
  );

  // Clock is only ever sampled, so no stretching is possible
  assign scl_s    = pins_s[3];
  assign sda_s    = pins_s[2];
  assign sel_en_s = pins_s[1];
  assign sel_s    = pins_s[0];

  assign start_ev = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_ev  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign scl_rise = scl_s & ~scl_q_reg;
  assign scl_fall = ~scl_s & scl_q_reg;

  assign my_id     = (sel_en_s & sel_s) ? DEV_ID_ALT : DEV_ID_DEF;
  assign byte_w    = {shift_reg[6:0], sda_s};
  assign rx_state  = (state_reg == D_DEVADDR) || (state_reg == D_RX);
  assign byte_done = scl_rise & rx_state & (bit_cnt_reg == BIT_LAST);
  assign hit       = byte_done & (state_reg == D_DEVADDR) & (byte_w[7:1] == my_id);
  assign rx_store  = byte_done & (state_reg == D_RX);
  assign tx_done   = scl_rise & (state_reg == D_TX) & (bit_cnt_reg == BIT_LAST);
  assign master_ack = scl_rise & (state_reg == D_TX) & (bit_cnt_reg == BIT_ACK)
                      & ~ack_drv_reg & ~sda_s;
  // Prefetch on read address match, and on each master acknowledge
  assign rd_issue  = (hit & byte_w[0]) | master_ack;
  assign wr_issue  = rx_store & (byte_idx_reg == 2'h2);

  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      ack_q_reg <= 1'b0;
    end
    else
    begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
      ack_q_reg <= ack_s;
    end
  end

  // Byte framing and protocol state
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg    <= D_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= BYTE_RST;
      ack_drv_reg  <= 1'b0;
      rd_mode_reg  <= 1'b0;
      byte_idx_reg <= 2'h0;
      addr_hi_reg  <= BYTE_RST;
    end
    else if (start_ev)
    begin
      state_reg    <= D_DEVADDR;
      bit_cnt_reg  <= 4'h0;
      ack_drv_reg  <= 1'b0;
      rd_mode_reg  <= 1'b0;
      byte_idx_reg <= 2'h0;
    end
    else if (stop_ev)
    begin
      state_reg   <= D_IDLE;
      ack_drv_reg <= 1'b0;
    end
    else if (scl_rise)
    begin
      case (state_reg)
        D_DEVADDR, D_RX:
        begin
          if (bit_cnt_reg < BIT_ACK)
          begin
            shift_reg   <= byte_w;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else
          begin
            bit_cnt_reg <= BIT_ACK_END;
          end
          if (hit)
          begin
            ack_drv_reg <= 1'b1;
            rd_mode_reg <= byte_w[0];
            state_reg   <= byte_w[0] ? D_TX : D_RX;
          end
          else if (byte_done && state_reg == D_DEVADDR)
          begin
            state_reg <= D_WAIT;
          end
          if (rx_store)
          begin
            ack_drv_reg <= 1'b1;
            if (byte_idx_reg == 2'h0)
            begin
              addr_hi_reg <= byte_w;
            end
            if (byte_idx_reg != 2'h2)
            begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end
        end
        D_TX:
        begin
          if (bit_cnt_reg < BIT_ACK)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (ack_drv_reg || !sda_s)
          begin
            bit_cnt_reg <= BIT_ACK_END;
          end
          else
          begin
            // No acknowledge ends the read; wait for stop or start
            state_reg <= D_WAIT;
          end
        end
        default:
        begin
          bit_cnt_reg <= bit_cnt_reg;
        end
      endcase
    end
    else if (scl_fall && bit_cnt_reg == BIT_ACK_END)
    begin
      bit_cnt_reg <= 4'h0;
      ack_drv_reg <= 1'b0;
    end
  end

  // Internal register address pointer
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ptr_reg <= PTR_RST;
    end
    else if (rx_store && byte_idx_reg == 2'h1)
    begin
      ptr_reg <= {addr_hi_reg, byte_w};
    end
    else if (wr_issue || tx_done)
    begin
      ptr_reg <= ptr_reg + 16'h0001;
    end
  end

  // Data line drive: low for acknowledge and for zero bits when sending
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
      tx_byte_reg <= BYTE_RST;
    end
    else if (start_ev || stop_ev || state_reg == D_IDLE || state_reg == D_WAIT)
    begin
      sda_oe_reg <= 1'b0;
    end
    else if (scl_fall)
    begin
      if (bit_cnt_reg == BIT_ACK)
      begin
        sda_oe_reg <= ack_drv_reg;
      end
      else if (bit_cnt_reg == BIT_ACK_END)
      begin
        tx_byte_reg <= rdata_link_reg;
        sda_oe_reg  <= rd_mode_reg & ~rdata_link_reg[7];
      end
      else if (state_reg == D_TX)
      begin
        sda_oe_reg <= ~tx_byte_reg[3'(BIT_LAST - bit_cnt_reg)];
      end
    end
  end

  assign link_if.d_sda_oe  = sda_oe_reg;
  assign link_if.d_sda_out = sda_out_reg;

  // Request toward the register port
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_tgl_reg    <= 1'b0;
      req_wr_reg     <= 1'b0;
      req_addr_reg   <= PTR_RST;
      req_data_reg   <= BYTE_RST;
      rdata_link_reg <= BYTE_IDLE;
    end
    else
    begin
      if (rd_issue || wr_issue)
      begin
        req_tgl_reg  <= ~req_tgl_reg;
        req_wr_reg   <= wr_issue;
        req_addr_reg <= ptr_reg;
        req_data_reg <= byte_w;
      end
      // Read data changes in the same system cycle as its toggle, and has settled before the synchronised toggle arrives
      if (ack_s != ack_q_reg)
      begin
        rdata_link_reg <= rdata_sys_reg;
      end
    end
  end

  // Register port on the system clock
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_q_reg     <= 1'b0;
      rd_pend_reg   <= 1'b0;
      ack_tgl_reg   <= 1'b0;
      rdata_sys_reg <= BYTE_IDLE;
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
      reg_addr_out  <= PTR_RST;
      reg_wdata_out <= BYTE_RST;
    end
    else
    begin
      req_q_reg   <= req_s;
      reg_wr_out  <= 1'b0;
      reg_rd_out  <= 1'b0;
      // Read data follows the strobe by one cycle, so sample one cycle late
      rd_pend_reg <= reg_rd_out;
      if (req_s != req_q_reg)
      begin
        reg_addr_out  <= req_addr_reg;
        reg_wdata_out <= req_data_reg;
        reg_wr_out    <= req_wr_reg;
        reg_rd_out    <= ~req_wr_reg;
      end
      if (rd_pend_reg)
      begin
        rdata_sys_reg <= reg_rdata_in;
        ack_tgl_reg   <= ~ack_tgl_reg;
      end
    end
  end

endmodule

// ---- core/twr_master.sv ----
// Two-wire bus master issuing register read and write transactions
`timescale 1ns/1ns
module twr_master
  import twr_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Command
  input  wire logic        cmd_valid_in,
  input  wire logic [1:0]  cmd_op_in,
  input  wire logic [15:0] cmd_addr_in,
  input  wire logic [7:0]  cmd_len_in,
  input  wire logic [6:0]  tgt_id_in,
  output logic             cmd_ready_out,
  // Write data
  input  wire logic [7:0]  wr_data_in,
  output logic             wr_take_out,
  // Read data and completion
  output logic [7:0]       rd_data_out,
  output logic             rd_valid_out,
  output logic             done_out,
  output logic             nack_out,
  // Link
  twr_link_if.master       link_if
);

  typedef enum logic [1:0] {
    M_IDLE,
    M_START,
    M_BIT,
    M_STOP
  } twr_mst_state_t;

  typedef enum logic [2:0] {
    P_DEV_W,
    P_AHI,
    P_ALO,
    P_DATA_W,
    P_DEV_R,
    P_DATA_R
  } twr_phase_t;

  twr_mst_state_t state_reg;
  twr_phase_t     phase_reg;
  twr_op_t        op_reg;
  logic [5:0]     tick_cnt_reg;
  logic [1:0]     q_reg;
  logic [3:0]     bit_cnt_reg;
  logic [7:0]     sh_reg;
  logic [7:0]     len_reg;
  logic [15:0]    addr_reg;
  logic [6:0]     id_reg;
  logic           scl_reg;
  logic           sda_oe_reg;
  logic           sda_out_reg;
  logic           sda_s;
  logic           tick;
  logic           tx_phase;
  logic [7:0]     load_byte;

  twr_sync2 #(
    .W (1)
  ) u_sda_sync (
    .clk_in (sys_clk_in),
    .rst_in (rst_in),
    .d_in   (link_if.sda),
    .q_out  (sda_s)
  );

  assign tick     = (tick_cnt_reg == QTR_LAST);
  assign tx_phase = (phase_reg != P_DATA_R);

  always_comb
  begin
    case (phase_reg)
      P_DEV_W:  load_byte = {id_reg, 1'b0};
      P_AHI:    load_byte = addr_reg[15:8];
      P_ALO:    load_byte = addr_reg[7:0];
      P_DATA_W: load_byte = wr_data_in;
      P_DEV_R:  load_byte = {id_reg, 1'b1};
      default:  load_byte = BYTE_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_cnt_reg <= 6'h00;
    end
    else if (state_reg == M_IDLE || tick)
    begin
      tick_cnt_reg <= 6'h00;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 6'h01;
    end
  end

  // Sequencer; both pins only change on quarter-bit ticks
  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg     <= M_IDLE;
      phase_reg     <= P_DEV_W;
      op_reg        <= TWR_OP_WRITE;
      q_reg         <= 2'h0;
      bit_cnt_reg   <= 4'h0;
      sh_reg        <= BYTE_IDLE;
      len_reg       <= 8'h01;
      addr_reg      <= PTR_RST;
      id_reg        <= DEV_ID_DEF;
      scl_reg       <= 1'b1;
      sda_oe_reg    <= 1'b0;
      sda_out_reg   <= 1'b0;
      cmd_ready_out <= 1'b1;
      wr_take_out   <= 1'b0;
      rd_data_out   <= BYTE_RST;
      rd_valid_out  <= 1'b0;
      done_out      <= 1'b0;
      nack_out      <= 1'b0;
    end
    else
    begin
      wr_take_out  <= 1'b0;
      rd_valid_out <= 1'b0;
      done_out     <= 1'b0;
      if (tick)
      begin
        q_reg <= q_reg + 2'h1;
      end
      case (state_reg)
        M_IDLE:
        begin
          q_reg <= 2'h0;
          if (cmd_valid_in)
          begin
            op_reg        <= twr_op_t'(cmd_op_in);
            addr_reg      <= cmd_addr_in;
            id_reg        <= tgt_id_in;
            len_reg       <= (cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
            phase_reg     <= (cmd_op_in == TWR_OP_READ_CUR) ? P_DEV_R : P_DEV_W;
            nack_out      <= 1'b0;
            cmd_ready_out <= 1'b0;
            state_reg     <= M_START;
          end
        end
        M_START:
        begin
          // Also serves as repeated start, with the clock low on entry
          if (tick)
          begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b1;
              default:
              begin
                scl_reg     <= 1'b0;
                bit_cnt_reg <= 4'h0;
                state_reg   <= M_BIT;
              end
            endcase
          end
        end
        M_BIT:
        begin
          if (tick)
          begin
            case (q_reg)
              2'h0:
              begin
                if (bit_cnt_reg == 4'h0)
                begin
                  sh_reg      <= load_byte;
                  sda_oe_reg  <= tx_phase & ~load_byte[7];
                  wr_take_out <= (phase_reg == P_DATA_W);
                end
                else if (bit_cnt_reg < BIT_ACK)
                begin
                  sda_oe_reg <= tx_phase & ~sh_reg[7];
                end
                else
                begin
                  // Acknowledge all read bytes but the last
                  sda_oe_reg <= ~tx_phase & (len_reg != 8'h01);
                end
              end
              2'h1: scl_reg <= 1'b1;
              2'h2: scl_reg <= 1'b1;
              default:
              begin
                scl_reg <= 1'b0;
                if (bit_cnt_reg < BIT_ACK)
                begin
                  sh_reg      <= {sh_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                else
                begin
                  bit_cnt_reg <= 4'h0;
                  if (tx_phase && sda_s)
                  begin
                    nack_out  <= 1'b1;
                    state_reg <= M_STOP;
                  end
                  else
                  begin
                    case (phase_reg)
                      P_DEV_W: phase_reg <= P_AHI;
                      P_AHI:   phase_reg <= P_ALO;
                      P_ALO:
                      begin
                        if (op_reg == TWR_OP_WRITE)
                        begin
                          phase_reg <= P_DATA_W;
                        end
                        else
                        begin
                          phase_reg <= P_DEV_R;
                          state_reg <= M_START;
                        end
                      end
                      P_DEV_R: phase_reg <= P_DATA_R;
                      P_DATA_W:
                      begin
                        len_reg <= len_reg - 8'h01;
                        if (len_reg == 8'h01)
                        begin
                          state_reg <= M_STOP;
                        end
                      end
                      default:
                      begin
                        rd_data_out  <= sh_reg;
                        rd_valid_out <= 1'b1;
                        len_reg      <= len_reg - 8'h01;
                        if (len_reg == 8'h01)
                        begin
                          state_reg <= M_STOP;
                        end
                      end
                    endcase
                  end
                end
              end
            endcase
          end
        end
        M_STOP:
        begin
          if (tick)
          begin
            case (q_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_reg <= 1'b1;
              2'h2: sda_oe_reg <= 1'b0;
              default:
              begin
                done_out      <= 1'b1;
                cmd_ready_out <= 1'b1;
                state_reg     <= M_IDLE;
              end
            endcase
          end
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end

  assign link_if.scl       = scl_reg;
  assign link_if.m_sda_oe  = sda_oe_reg;
  assign link_if.m_sda_out = sda_out_reg;

endmodule

// ---- test/twr_link_monitor.sv ----
// Protocol checker watching both ends of the two-wire link
`timescale 1ns/1ns
module twr_link_monitor
  import twr_pkg::*;
(
  // Clocks and reset
  input  wire logic sys_clk_in,
  input  wire logic link_clk_in,
  input  wire logic rst_in,
  // Link signals
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic m_sda_oe,
  input  wire logic m_sda_out,
  input  wire logic d_sda_oe,
  input  wire logic d_sda_out
);
  localparam int HALF = 2 * QTR_CYC;
  logic        scl_q_reg;
  logic [11:0] run_reg;

  // Length of the current clock level, saturating so idle time cannot wrap
  always_ff @(posedge sys_clk_in or posedge rst_in)
    if (rst_in)
    begin
      scl_q_reg <= 1'b1;
      run_reg   <= 12'h000;
    end
    else
    begin
      scl_q_reg <= scl;
      run_reg   <= (scl != scl_q_reg) ? 12'h001 : run_reg + 12'(run_reg != 12'hfff);
    end

  chk_low_period: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(scl) |-> run_reg == 12'(HALF)) else $error("clock low time wrong");
  chk_high_period: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(scl) |-> run_reg >= 12'(HALF)) else $error("clock high time short");
  chk_start_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $fell(sda) && scl |-> scl [*8]) else $error("start not held");
  chk_stop_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(sda) && scl && $past(scl) |-> (scl && sda) [*8]) else $error("stop not idle");
  chk_m_open_drain: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    m_sda_oe |-> !m_sda_out) else $error("master drives data high");
  chk_d_open_drain: assert property (@(posedge link_clk_in) disable iff (rst_in)
    d_sda_oe |-> !d_sda_out) else $error("target drives data high");
  chk_dev_scl_low: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $changed(d_sda_oe) |-> !scl) else $error("target moved data with clock high");
  chk_ack_hold: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $rose(d_sda_oe) |-> d_sda_oe [*8]) else $error("target low drive too short");
endmodule

// ---- test/tb.sv ----
// Testbench: master and target joined on the link, register file modelled
`timescale 1ns/1ns
module tb;
  import twr_pkg::*;
  logic        sys_clk_in, link_clk_in, rst_in, cmd_valid_in, addr_sel_en_in, addr_sel_in;
  logic        cmd_ready_out, wr_take_out, rd_valid_out, done_out, nack_out;
  logic        reg_wr_out, reg_rd_out;
  logic [1:0]  cmd_op_in;
  logic [15:0] cmd_addr_in, reg_addr_out, ptr;
  logic [7:0]  cmd_len_in, wr_data_in, reg_rdata_in, rd_data_out, reg_wdata_out;
  logic [6:0]  tgt_id_in;
  logic [7:0]  mem [0:65535];
  logic [7:0]  shadow [0:65535];
  logic [7:0]  wq[$];
  logic [23:0] exp_rd[$], exp_wr[$], exp_ra[$];
  logic        exp_nk[$];
  int          err_count, n_checks;

  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #7;
    forever #15 link_clk_in = ~link_clk_in;
  end

  twr_link_if link ();
  twr_master twr_master_inst (.sys_clk_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in,
    .cmd_len_in, .tgt_id_in, .cmd_ready_out, .wr_data_in, .wr_take_out, .rd_data_out,
    .rd_valid_out, .done_out, .nack_out, .link_if(link.master));
  twr_target twr_target_inst (.link_clk_in, .sys_clk_in, .rst_in, .link_if(link.device),
    .addr_sel_en_in, .addr_sel_in, .reg_wr_out, .reg_rd_out, .reg_addr_out, .reg_wdata_out,
    .reg_rdata_in);
  twr_link_monitor twr_link_monitor_inst (.sys_clk_in, .link_clk_in, .rst_in, .scl(link.scl),
    .sda(link.sda), .m_sda_oe(link.m_sda_oe), .m_sda_out(link.m_sda_out),
    .d_sda_oe(link.d_sda_oe), .d_sda_out(link.d_sda_out));

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Register file; read data lags the address by a cycle, as the port expects
  always @(posedge sys_clk_in)
  begin
    if (reg_wr_out === 1'b1) mem[reg_addr_out] <= reg_wdata_out;
    reg_rdata_in <= mem[reg_addr_out];
    if (wr_take_out === 1'b1) void'(wq.pop_front());
    wr_data_in <= (wq.size() > 0) ? wq[0] : 8'h00;
  end

  // Results are taken mid-cycle so pulses launched at an edge have settled
  always @(negedge sys_clk_in)
  begin
    if (rd_valid_out === 1'b1)
      chk("rd_data", rd_data_out, exp_rd.size() ? exp_rd.pop_front() : 'x);
    if (reg_wr_out === 1'b1)
      chk("reg_write", {reg_addr_out, reg_wdata_out}, exp_wr.size() ? exp_wr.pop_front() : 'x);
    if (reg_rd_out === 1'b1)
      chk("reg_read", reg_addr_out, exp_ra.size() ? exp_ra.pop_front() : 'x);
    if (done_out === 1'b1)
    begin
      chk("nack", nack_out, exp_nk.size() ? exp_nk.pop_front() : 'x);
      chk("bus_idle", {link.scl, link.sda}, 24'h3);
      chk("ready", cmd_ready_out, 24'h1);
    end
  end

  task automatic run(input twr_op_t op, input logic [15:0] a, input logic [7:0] n,
                     input logic [6:0] id, input logic nk);
    logic [15:0] p;
    logic [7:0]  d;
    int          t;
    p = (op == TWR_OP_READ_CUR) ? ptr : a;
    exp_nk.push_back(nk);
    for (int i = 0; i < n && !nk; i++)
    begin
      d = 8'($urandom);
      if (op == TWR_OP_WRITE)
      begin
        wq.push_back(d);
        exp_wr.push_back({p, d});
        shadow[p] = d;
      end
      else
      begin
        exp_rd.push_back({16'h0000, shadow[p]});
        exp_ra.push_back({8'h00, p});
      end
      p = p + 16'h0001;
    end
    if (!nk) ptr = p;
    @(posedge sys_clk_in);
    cmd_op_in    <= op;
    cmd_addr_in  <= a;
    cmd_len_in   <= n;
    tgt_id_in    <= id;
    cmd_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    t = 0;
    do
    begin
      @(negedge sys_clk_in);
      t++;
    end
    while (done_out !== 1'b1 && t < 30000);
    if (t >= 30000)
    begin
      chk("done_wait", 24'h0, 24'h1);
      report_and_stop();
    end
  endtask

  task automatic end_test(input string nm);
    @(posedge sys_clk_in);
    chk("pending", 24'(exp_rd.size() + exp_wr.size() + exp_nk.size() + exp_ra.size()),
        24'h0);
    $display("test %s done, mismatches %0d", nm, err_count);
  endtask

  initial
  begin
    rst_in = 1'b1;
    {cmd_valid_in, addr_sel_en_in, addr_sel_in} = 3'h0;
    cmd_op_in = 2'h0;
    cmd_addr_in = 16'h0000;
    cmd_len_in = 8'h00;
    tgt_id_in = 7'h00;
    err_count = 0;
    n_checks = 0;
    ptr = PTR_RST;
    void'($urandom(36225));
    for (int i = 0; i < 65536; i++)
    begin
      mem[i] = 8'(i * 7 + 3);
      shadow[i] = mem[i];
    end
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    run(TWR_OP_WRITE, 16'h1234, 8'h01, DEV_ID_DEF, 1'b0);
    run(TWR_OP_READ_RAND, 16'h1234, 8'h01, DEV_ID_DEF, 1'b0);
    run(TWR_OP_READ_CUR, 16'h0000, 8'h01, DEV_ID_DEF, 1'b0);
    end_test("single");
    // Pointer wraps through the top of the address space
    run(TWR_OP_WRITE, 16'hfffe, 8'h03, DEV_ID_DEF, 1'b0);
    run(TWR_OP_READ_RAND, 16'hfffe, 8'h04, DEV_ID_DEF, 1'b0);
    run(TWR_OP_READ_CUR, 16'h0000, 8'h02, DEV_ID_DEF, 1'b0);
    end_test("sequential");
    addr_sel_en_in <= 1'b1;
    addr_sel_in    <= 1'b1;
    run(TWR_OP_WRITE, 16'h00c0, 8'h02, DEV_ID_ALT, 1'b0);
    run(TWR_OP_READ_CUR, 16'h0000, 8'h01, DEV_ID_DEF, 1'b1);
    run(TWR_OP_READ_RAND, 16'h00c0, 8'h02, DEV_ID_ALT, 1'b0);
    addr_sel_en_in <= 1'b0;
    run(TWR_OP_READ_CUR, 16'h0000, 8'h01, DEV_ID_ALT, 1'b1);
    run(TWR_OP_WRITE, 16'h0100, 8'h01, DEV_ID_DEF, 1'b0);
    end_test("address_select");
    repeat (3)
      run(twr_op_t'($urandom_range(2, 0)), 16'($urandom), 8'($urandom_range(2, 1)),
          DEV_ID_DEF, 1'b0);
    end_test("random");
    report_and_stop();
  end
endmodule
